// ==== gph_gpio_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module gph_gpio_top
   import gph_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_n,
   // Register port
   input  wire gph_bus_t   bus,
   output var  logic [31:0] bus_rdata,
   // Port G pads
   input  wire logic [15:0] g_pad_in,
   output var  logic [15:0] g_pad_out,
   output var  logic [15:0] g_pad_oe,
   output var  logic [15:0] g_pullup_dis,
   // Port H pads
   input  wire logic [10:0] h_pad_in,
   output var  logic [10:0] h_pad_out,
   output var  logic [10:0] h_pad_oe,
   output var  logic [10:0] h_pullup_dis,
   // Peripheral function paths
   input  wire gph_drv_t   drv,
   output var  gph_fwd_t   fwd
);

   gph_state_t st_r;
   gph_state_t st_nxt;

   always_comb begin
      logic [15:0] g_rd;
      logic [10:0] h_rd;
      logic [31:0] h_fsel32;
      gph_mode_t   m;
      g_rd     = 16'h0000;
      h_rd     = 11'h000;
      h_fsel32 = {10'h000, st_r.h_fsel};
      m        = GPH_MODE_IN;
      st_nxt   = st_r;
      st_nxt.rdata = RDATA_RST;

      // Port G pins.
      for (int i = 0; i < G_PINS; i++) begin
         m = gph_pin_mode(st_r.g_fsel, i);
         // Function pins read the pad level; software must not rely on it.
         g_rd[i] = (m == GPH_MODE_OUT) ? st_r.g_data[i] : g_pad_in[i];
         st_nxt.g_out[i] = 1'h0;
         st_nxt.g_oe[i]  = 1'h0;
         st_nxt.fwd.external_irq_input[i] = (m == GPH_MODE_FN2) & g_pad_in[i];
         case (m)
            GPH_MODE_OUT: begin
               st_nxt.g_oe[i]  = 1'h1;
               st_nxt.g_out[i] = st_r.g_data[i];
            end
            GPH_MODE_FN3: begin
               case (i)
                  9: begin
                     st_nxt.g_oe[i]  = 1'h1;
                     st_nxt.g_out[i] = drv.uart1_request_to_send;
                  end
                  4: begin
                     st_nxt.g_oe[i]  = 1'h1;
                     st_nxt.g_out[i] = drv.display_power_down;
                  end
                  7: begin
                     st_nxt.g_oe[i]  = drv.spi1_serial_clock_oe;
                     st_nxt.g_out[i] = drv.spi1_serial_clock_o;
                  end
                  6: begin
                     st_nxt.g_oe[i]  = drv.spi1_master_out_oe;
                     st_nxt.g_out[i] = drv.spi1_master_out_o;
                  end
                  5: begin
                     st_nxt.g_oe[i]  = drv.spi1_master_in_oe;
                     st_nxt.g_out[i] = drv.spi1_master_in_o;
                  end
                  // Inputs and reserved codes leave the pad undriven.
                  default: begin
                  end
               endcase
            end
            default: begin
            end
         endcase
      end

      // Port H pins.
      for (int i = 0; i < H_PINS; i++) begin
         m = gph_pin_mode(h_fsel32, i);
         h_rd[i] = (m == GPH_MODE_OUT) ? st_r.h_data[i] : h_pad_in[i];
         st_nxt.h_out[i] = 1'h0;
         st_nxt.h_oe[i]  = 1'h0;
         case (m)
            GPH_MODE_OUT: begin
               st_nxt.h_oe[i]  = 1'h1;
               st_nxt.h_out[i] = st_r.h_data[i];
            end
            GPH_MODE_FN2: begin
               st_nxt.h_oe[i] = 1'h1;
               case (i)
                  10: st_nxt.h_out[i] = drv.clock_output_1;
                  9: st_nxt.h_out[i] = drv.clock_output_0;
                  6: st_nxt.h_out[i] = drv.uart2_transmit;
                  4: st_nxt.h_out[i] = drv.uart1_transmit;
                  2: st_nxt.h_out[i] = drv.uart0_transmit;
                  1: st_nxt.h_out[i] = drv.uart0_request_to_send;
                  default: st_nxt.h_oe[i] = 1'h0;
               endcase
            end
            GPH_MODE_FN3: begin
               if (i == 6) begin
                  st_nxt.h_oe[i]  = 1'h1;
                  st_nxt.h_out[i] = drv.uart1_request_to_send;
               end
            end
            default: begin
            end
         endcase
      end

      // Named function inputs; unselected paths rest at their idle level.
      st_nxt.fwd.timer_clock_input_1 =
         (gph_pin_mode(st_r.g_fsel, 11) == GPH_MODE_FN3) & g_pad_in[11];
      // Port G wins if software selects both clear-to-send pins at once.
      if (gph_pin_mode(st_r.g_fsel, 10) == GPH_MODE_FN3) begin
         st_nxt.fwd.uart1_clear_to_send = g_pad_in[10];
      end else if (gph_pin_mode(h_fsel32, 7) == GPH_MODE_FN3) begin
         st_nxt.fwd.uart1_clear_to_send = h_pad_in[7];
      end else begin
         st_nxt.fwd.uart1_clear_to_send = FWD_IDLE.uart1_clear_to_send;
      end
      st_nxt.fwd.spi1_serial_clock =
         (gph_pin_mode(st_r.g_fsel, 7) == GPH_MODE_FN3) & g_pad_in[7];
      st_nxt.fwd.spi1_master_out =
         (gph_pin_mode(st_r.g_fsel, 6) == GPH_MODE_FN3) & g_pad_in[6];
      st_nxt.fwd.spi1_master_in =
         (gph_pin_mode(st_r.g_fsel, 5) == GPH_MODE_FN3) & g_pad_in[5];
      st_nxt.fwd.slave_select_1 =
         (gph_pin_mode(st_r.g_fsel, 3) == GPH_MODE_FN3) ? g_pad_in[3] : 1'h1;
      st_nxt.fwd.slave_select_0 =
         (gph_pin_mode(st_r.g_fsel, 2) == GPH_MODE_FN3) ? g_pad_in[2] : 1'h1;
      st_nxt.fwd.uart_external_clock =
         (gph_pin_mode(h_fsel32, 8) == GPH_MODE_FN2) & h_pad_in[8];
      st_nxt.fwd.uart2_receive =
         (gph_pin_mode(h_fsel32, 7) == GPH_MODE_FN2) ? h_pad_in[7] : 1'h1;
      st_nxt.fwd.uart1_receive =
         (gph_pin_mode(h_fsel32, 5) == GPH_MODE_FN2) ? h_pad_in[5] : 1'h1;
      st_nxt.fwd.uart0_receive =
         (gph_pin_mode(h_fsel32, 3) == GPH_MODE_FN2) ? h_pad_in[3] : 1'h1;
      st_nxt.fwd.uart0_clear_to_send =
         (gph_pin_mode(h_fsel32, 0) == GPH_MODE_FN2) ? h_pad_in[0] : 1'h1;

      // Register writes; unmapped and reserved words ignore them.
      if (bus.wr) begin
         if (bus.addr == G_FSEL_ADDR) begin
            st_nxt.g_fsel = bus.wdata;
         end else if (bus.addr == G_DATA_ADDR) begin
            st_nxt.g_data = bus.wdata[15:0];
         end else if (bus.addr == G_PUD_ADDR) begin
            st_nxt.g_pud = bus.wdata[15:0];
         end else if (bus.addr == H_FSEL_ADDR) begin
            st_nxt.h_fsel = bus.wdata[21:0];
         end else if (bus.addr == H_DATA_ADDR) begin
            st_nxt.h_data = bus.wdata[10:0];
         end else if (bus.addr == H_PUD_ADDR) begin
            st_nxt.h_pud = bus.wdata[10:0];
         end
      end

      // Read data stands only in the cycle after the strobe.
      if (bus.rd) begin
         if (bus.addr == G_FSEL_ADDR) begin
            st_nxt.rdata = st_r.g_fsel;
         end else if (bus.addr == G_DATA_ADDR) begin
            st_nxt.rdata = {16'h0000, g_rd};
         end else if (bus.addr == G_PUD_ADDR) begin
            st_nxt.rdata = {16'h0000, st_r.g_pud};
         end else if (bus.addr == H_FSEL_ADDR) begin
            st_nxt.rdata = h_fsel32;
         end else if (bus.addr == H_DATA_ADDR) begin
            st_nxt.rdata = {21'h00_0000, h_rd};
         end else if (bus.addr == H_PUD_ADDR) begin
            st_nxt.rdata = {21'h00_0000, st_r.h_pud};
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= STATE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus_rdata    = st_r.rdata;
   assign g_pad_out    = st_r.g_out;
   assign g_pad_oe     = st_r.g_oe;
   assign g_pullup_dis = st_r.g_pud;
   assign h_pad_out    = st_r.h_out;
   assign h_pad_oe     = st_r.h_oe;
   assign h_pullup_dis = st_r.h_pud;
   assign fwd          = st_r.fwd;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   AST_OUT_DRIVE: assert property (
      (st_r.g_fsel[1:0] == 2'h1) |=> (g_pad_oe[0] && g_pad_out[0] == $past(st_r.g_data[0])))
      else $error("output pin does not follow data bit");

   AST_IN_READ: assert property (
      (bus.rd && bus.addr == G_DATA_ADDR && st_r.g_fsel[1:0] == 2'h0)
      |=> (bus_rdata[0] == $past(g_pad_in[0]) && bus_rdata[31:16] == 16'h0000))
      else $error("input pin read does not return pad level");

   // Pin 12 is watched because software keeps the top three pins as inputs.
   AST_IRQ_ROUTE: assert property (
      (st_r.g_fsel[25:24] == 2'h2) |=> (fwd.external_irq_input[12] == $past(g_pad_in[12])))
      else $error("irq input not routed from pin");

   AST_PUD_WRITE: assert property (
      (bus.wr && bus.addr == G_PUD_ADDR) |=> (g_pullup_dis == $past(bus.wdata[15:0])))
      else $error("pull-up write not taken");

   AST_RSVD_FLOAT: assert property (
      (st_r.g_fsel[3:2] == 2'h3) |=> !g_pad_oe[1])
      else $error("reserved code drives the pad");

   AST_SPI_CLK: assert property (
      (st_r.g_fsel[15:14] == 2'h3)
      |=> (g_pad_oe[7] == $past(drv.spi1_serial_clock_oe)
           && fwd.spi1_serial_clock == $past(g_pad_in[7])))
      else $error("spi clock path wrong");

   AST_LCD_OFF: assert property (
      (st_r.g_fsel[9:8] == 2'h3)
      |=> (g_pad_oe[4] && g_pad_out[4] == $past(drv.display_power_down)))
      else $error("display power-down path wrong");

   AST_UART0_TX: assert property (
      (st_r.h_fsel[5:4] == 2'h2)
      |=> (h_pad_oe[2] && h_pad_out[2] == $past(drv.uart0_transmit)))
      else $error("uart0 transmit path wrong");

   AST_CLK_OUT: assert property (
      (st_r.h_fsel[21:20] == 2'h2)
      |=> (h_pad_oe[10] && h_pad_out[10] == $past(drv.clock_output_1)))
      else $error("clock output 1 path wrong");

   AST_H_RTS1: assert property (
      (st_r.h_fsel[13:12] == 2'h3)
      |=> (h_pad_oe[6] && h_pad_out[6] == $past(drv.uart1_request_to_send)))
      else $error("uart1 request-to-send on port H wrong");

   AST_RSVD_WORD: assert property (
      (bus.rd && bus.addr == H_RSVD_ADDR) |=> (bus_rdata == 32'h0000_0000))
      else $error("reserved word read not zero");

   AST_READ_ONCE: assert property (
      !bus.rd |=> (bus_rdata == 32'h0000_0000))
      else $error("read data held beyond its cycle");

   AST_G_PUD_RST: assert property (
      $rose(rst_n) |-> (g_pullup_dis == G_PUD_RST))
      else $error("port G pull-up reset value wrong");

   AST_H_PUD_RST: assert property (
      $rose(rst_n) |-> (h_pullup_dis == H_PUD_RST))
      else $error("port H pull-up reset value wrong");

   AST_MODE_RST: assert property (
      $rose(rst_n) |-> (st_r.g_fsel == G_FSEL_RST && st_r.h_fsel == H_FSEL_RST
                        && g_pad_oe == 16'h0000 && h_pad_oe == 11'h000))
      else $error("pins not inputs after reset");

   AST_IN_FLOAT: assert property (
      (st_r.g_fsel[1:0] == 2'h0) |=> !g_pad_oe[0])
      else $error("input pin drives the pad");

   AST_IRQ_IDLE: assert property (
      (st_r.g_fsel[25:24] != 2'h2) |=> !fwd.external_irq_input[12])
      else $error("irq input forwarded without irq mode");

   AST_TIMER_IN: assert property (
      (st_r.g_fsel[23:22] == 2'h3)
      |=> (fwd.timer_clock_input_1 == $past(g_pad_in[11]) && !g_pad_oe[11]))
      else $error("timer clock input path wrong");

   AST_G_CTS1: assert property (
      (st_r.g_fsel[21:20] == 2'h3)
      |=> (fwd.uart1_clear_to_send == $past(g_pad_in[10]) && !g_pad_oe[10]))
      else $error("uart1 clear-to-send on port G wrong");

   AST_G_RTS1: assert property (
      (st_r.g_fsel[19:18] == 2'h3)
      |=> (g_pad_oe[9] && g_pad_out[9] == $past(drv.uart1_request_to_send)))
      else $error("uart1 request-to-send on port G wrong");

   AST_SPI_MOSI: assert property (
      (st_r.g_fsel[13:12] == 2'h3)
      |=> (g_pad_oe[6] == $past(drv.spi1_master_out_oe)
           && g_pad_out[6] == $past(drv.spi1_master_out_o)
           && fwd.spi1_master_out == $past(g_pad_in[6])))
      else $error("spi master-out path wrong");

   AST_SPI_MISO: assert property (
      (st_r.g_fsel[11:10] == 2'h3)
      |=> (g_pad_oe[5] == $past(drv.spi1_master_in_oe)
           && g_pad_out[5] == $past(drv.spi1_master_in_o)
           && fwd.spi1_master_in == $past(g_pad_in[5])))
      else $error("spi master-in path wrong");

   AST_SEL_IN: assert property (
      (st_r.g_fsel[7:4] == 4'hf)
      |=> (fwd.slave_select_1 == $past(g_pad_in[3]) && fwd.slave_select_0 == $past(g_pad_in[2])
           && g_pad_oe[3:2] == 2'b00))
      else $error("slave select path wrong");

   AST_H_DRIVE: assert property (
      (st_r.h_fsel[21:20] == 2'h1)
      |=> (h_pad_oe[10] && h_pad_out[10] == $past(st_r.h_data[10])))
      else $error("port H output pin does not follow data bit");

   AST_H_READ: assert property (
      (bus.rd && bus.addr == H_DATA_ADDR && st_r.h_fsel[1:0] == 2'h1)
      |=> (bus_rdata[0] == $past(st_r.h_data[0]) && bus_rdata[31:11] == 21'h00_0000))
      else $error("port H data read wrong");

   AST_H_PUD_WRITE: assert property (
      (bus.wr && bus.addr == H_PUD_ADDR) |=> (h_pullup_dis == $past(bus.wdata[10:0])))
      else $error("port H pull-up write not taken");

   AST_RX2_IN: assert property (
      (st_r.h_fsel[15:14] == 2'h2)
      |=> (fwd.uart2_receive == $past(h_pad_in[7]) && !h_pad_oe[7]))
      else $error("uart2 receive path wrong");

   AST_CTS0_IN: assert property (
      (st_r.h_fsel[1:0] == 2'h2)
      |=> (fwd.uart0_clear_to_send == $past(h_pad_in[0]) && !h_pad_oe[0]))
      else $error("uart0 clear-to-send path wrong");

   AST_H_CTS1: assert property (
      (st_r.h_fsel[15:14] == 2'h3 && st_r.g_fsel[21:20] != 2'h3)
      |=> (fwd.uart1_clear_to_send == $past(h_pad_in[7]) && !h_pad_oe[7]))
      else $error("uart1 clear-to-send on port H wrong");

   AST_H_RSVD: assert property (
      (st_r.h_fsel[17:16] == 2'h3)
      |=> (!h_pad_oe[8] && !fwd.uart_external_clock))
      else $error("reserved code on port H connects a function");

   COV_OUT_MODE: cover property (
      (bus.wr && bus.addr == G_FSEL_ADDR) ##1 (st_r.g_fsel[1:0] == 2'h1) ##1 g_pad_oe[0]);
   COV_SPI_SEL: cover property ((st_r.g_fsel[15:14] == 2'h3) ##1 g_pad_oe[7]);
   COV_H_READ: cover property ((bus.rd && bus.addr == H_DATA_ADDR) ##1 bus_rdata[0]);

endmodule
`default_nettype wire

// ==== gph_pkg.sv ====
`default_nettype none
package gph_pkg;

   localparam int G_PINS = 16;
   localparam int H_PINS = 11;

   // Register byte addresses.
   localparam logic [31:0] G_FSEL_ADDR = 32'h5600_0060;
   localparam logic [31:0] G_DATA_ADDR = 32'h5600_0064;
   localparam logic [31:0] G_PUD_ADDR  = 32'h5600_0068;
   localparam logic [31:0] H_FSEL_ADDR = 32'h5600_0070;
   localparam logic [31:0] H_DATA_ADDR = 32'h5600_0074;
   localparam logic [31:0] H_PUD_ADDR  = 32'h5600_0078;
   localparam logic [31:0] H_RSVD_ADDR = 32'h5600_007c;

   // Values after reset.
   localparam logic [31:0] G_FSEL_RST = 32'h0000_0000;
   localparam logic [15:0] G_DATA_RST = 16'h0000;
   localparam logic [15:0] G_PUD_RST  = 16'hfc00;
   localparam logic [21:0] H_FSEL_RST = 22'h00_0000;
   localparam logic [10:0] H_DATA_RST = 11'h000;
   localparam logic [10:0] H_PUD_RST  = 11'h000;
   localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

   // Pin modes in field-code order: 00, 01, 10, 11.
   typedef enum logic [1:0] {
      GPH_MODE_IN,
      GPH_MODE_OUT,
      GPH_MODE_FN2,
      GPH_MODE_FN3
   } gph_mode_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } gph_bus_t;

   // Peripherals to pins.
   typedef struct packed {
      logic spi1_serial_clock_o;
      logic spi1_serial_clock_oe;
      logic spi1_master_out_o;
      logic spi1_master_out_oe;
      logic spi1_master_in_o;
      logic spi1_master_in_oe;
      logic uart1_request_to_send;
      logic display_power_down;
      logic clock_output_1;
      logic clock_output_0;
      logic uart2_transmit;
      logic uart1_transmit;
      logic uart0_transmit;
      logic uart0_request_to_send;
   } gph_drv_t;

   // Pins to peripherals.
   typedef struct packed {
      logic [15:0] external_irq_input;
      logic        timer_clock_input_1;
      logic        uart1_clear_to_send;
      logic        spi1_serial_clock;
      logic        spi1_master_out;
      logic        spi1_master_in;
      logic        slave_select_1;
      logic        slave_select_0;
      logic        uart_external_clock;
      logic        uart2_receive;
      logic        uart1_receive;
      logic        uart0_receive;
      logic        uart0_clear_to_send;
   } gph_fwd_t;

   // Idle levels: active-low selects and serial receive lines rest high.
   localparam gph_fwd_t FWD_IDLE = '{
      external_irq_input:  16'h0000,
      timer_clock_input_1: 1'h0,
      uart1_clear_to_send: 1'h1,
      spi1_serial_clock:   1'h0,
      spi1_master_out:     1'h0,
      spi1_master_in:      1'h0,
      slave_select_1:      1'h1,
      slave_select_0:      1'h1,
      uart_external_clock: 1'h0,
      uart2_receive:       1'h1,
      uart1_receive:       1'h1,
      uart0_receive:       1'h1,
      uart0_clear_to_send: 1'h1
   };

   typedef struct packed {
      logic [31:0] g_fsel;
      logic [15:0] g_data;
      logic [15:0] g_pud;
      logic [21:0] h_fsel;
      logic [10:0] h_data;
      logic [10:0] h_pud;
      logic [31:0] rdata;
      logic [15:0] g_out;
      logic [15:0] g_oe;
      logic [10:0] h_out;
      logic [10:0] h_oe;
      gph_fwd_t    fwd;
   } gph_state_t;

   localparam gph_state_t STATE_RST = '{
      g_fsel: G_FSEL_RST,
      g_data: G_DATA_RST,
      g_pud:  G_PUD_RST,
      h_fsel: H_FSEL_RST,
      h_data: H_DATA_RST,
      h_pud:  H_PUD_RST,
      rdata:  RDATA_RST,
      g_out:  16'h0000,
      g_oe:   16'h0000,
      h_out:  11'h000,
      h_oe:   11'h000,
      fwd:    FWD_IDLE
   };

   function automatic gph_mode_t gph_pin_mode(input logic [31:0] fsel, input int n);
      return gph_mode_t'(fsel[2*n +: 2]);
   endfunction

endpackage
`default_nettype wire

// ==== gph_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// Board side of one port: pads, pull-ups and whatever the board drives onto them.
module gph_pin_model #(
   parameter int W = 16
) (
   // Clock
   input  wire logic         mclk,
   // Chip side of each pad
   input  wire logic [W-1:0] out,
   input  wire logic [W-1:0] oe,
   input  wire logic [W-1:0] pud,
   // Board drivers
   input  wire logic [W-1:0] ext,
   input  wire logic [W-1:0] ext_en,
   // Resolved pad level
   output var  logic [W-1:0] lvl
);
   logic [W-1:0] flip_r = '0;

   // A floating pad without its pull-up has no stable level, so it toggles every cycle.
   always_ff @(posedge mclk) begin
      flip_r <= ~flip_r;
   end

   // The chip wins over the board, the board over the pull-up.
   assign lvl = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & (~pud | flip_r));
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; $display("[ERR] t=%0t got %0h exp %0h", $time, (got), (exp)); end end

module testbench;
   import gph_pkg::*;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   gph_bus_t    bus = '0;
   gph_drv_t    drv = '0;
   gph_drv_t    r;
   gph_fwd_t    fwd;
   logic [31:0] bus_rdata;
   logic [31:0] d;
   logic [31:0] ex;
   logic [15:0] g_pad_in, g_pad_out, g_pad_oe, g_pullup_dis, oe_x, lv;
   logic [15:0] ext_g = '0;
   logic [15:0] ext_g_en = '0;
   logic [10:0] h_pad_in, h_pad_out, h_pad_oe, h_pullup_dis;
   logic [10:0] ext_h = '0;
   logic [10:0] ext_h_en = '0;
   logic [31:0] exp_q[$];
   logic        rd_seen = 1'b0;
   int          failures = 0;
   int          comparisons = 0;

   always #5 mclk = ~mclk;

   gph_gpio_top uut (.mclk(mclk), .rst_n(rst_n), .bus(bus), .bus_rdata(bus_rdata),
      .g_pad_in(g_pad_in), .g_pad_out(g_pad_out), .g_pad_oe(g_pad_oe),
      .g_pullup_dis(g_pullup_dis), .h_pad_in(h_pad_in), .h_pad_out(h_pad_out),
      .h_pad_oe(h_pad_oe), .h_pullup_dis(h_pullup_dis), .drv(drv), .fwd(fwd));
   gph_pin_model #(.W(16)) pins_g (.mclk(mclk), .out(g_pad_out), .oe(g_pad_oe),
      .pud(g_pullup_dis), .ext(ext_g), .ext_en(ext_g_en), .lvl(g_pad_in));
   gph_pin_model #(.W(11)) pins_h (.mclk(mclk), .out(h_pad_out), .oe(h_pad_oe),
      .pud(h_pullup_dis), .ext(ext_h), .ext_en(ext_h_en), .lvl(h_pad_in));

   // Read data stands only in the cycle after the strobe, so it is checked mid-cycle there.
   always @(posedge mclk) rd_seen <= bus.rd;
   always @(negedge mclk) begin
      if (rd_seen) begin
         ex = exp_q.pop_front();
         `CHK(bus_rdata, ex)
      end
   end

   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge mclk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus <= '0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] v);
      exp_q.push_back(v);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus <= '0;
   endtask

   // Peripheral drive reaches the pad, comes back in and is registered: two edges, and settle waits three.
   task automatic settle;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic conclude;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge mclk);
      failures++;
      conclude();
   end

   initial begin
      void'($urandom(96690));
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      `CHK({g_pullup_dis, h_pullup_dis}, 27'h7e0_0000)
      `CHK({g_pad_oe, h_pad_oe}, 27'h000_0000)
      rd(G_FSEL_ADDR, 32'h0000_0000);
      rd(G_PUD_ADDR, 32'h0000_fc00);
      rd(H_FSEL_ADDR, 32'h0000_0000);
      rd(H_PUD_ADDR, 32'h0000_0000);
      // Top three port G pins stay inputs, as boot from flash demands.
      for (int i = 0; i < 4; i++) begin
         d = $urandom();
         wr(G_FSEL_ADDR, d & 32'h03ff_ffff);
         rd(G_FSEL_ADDR, d & 32'h03ff_ffff);
         wr(H_FSEL_ADDR, d);
         rd(H_FSEL_ADDR, d & 32'h003f_ffff);
         wr(G_PUD_ADDR, d);
         rd(G_PUD_ADDR, d & 32'h0000_ffff);
         wr(H_PUD_ADDR, ~d);
         rd(H_PUD_ADDR, ~d & 32'h0000_07ff);
         wr(H_RSVD_ADDR, d);
         rd(H_RSVD_ADDR, 32'h0000_0000);
         rd(32'h5600_0080, 32'h0000_0000);
      end
      wr(G_FSEL_ADDR, 32'h0000_0000);
      wr(H_FSEL_ADDR, 32'h0000_0000);
      d = $urandom();
      ext_g <= d[15:0];
      ext_h <= d[26:16];
      ext_g_en <= '1;
      ext_h_en <= '1;
      rd(G_DATA_ADDR, {16'h0000, d[15:0]});
      rd(H_DATA_ADDR, {21'h00_0000, d[26:16]});
      @(negedge mclk);
      `CHK({g_pad_oe, h_pad_oe}, 27'h000_0000)
      @(posedge mclk);
      ext_g_en <= '0;
      ext_h_en <= '0;
      wr(G_PUD_ADDR, 32'h0000_0000);
      wr(H_PUD_ADDR, 32'h0000_0000);
      rd(G_DATA_ADDR, 32'h0000_ffff);
      rd(H_DATA_ADDR, 32'h0000_07ff);
      ext_g_en <= '1;
      ext_h_en <= '1;
      wr(G_FSEL_ADDR, 32'h0155_5555);
      wr(H_FSEL_ADDR, 32'h0015_5555);
      d = $urandom();
      wr(G_DATA_ADDR, d);
      wr(H_DATA_ADDR, d >> 16);
      settle();
      `CHK(g_pad_oe, 16'h1fff)
      `CHK(g_pad_out & 16'h1fff, d[15:0] & 16'h1fff)
      `CHK({h_pad_oe, h_pad_out}, {11'h7ff, d[26:16]})
      rd(G_DATA_ADDR, {16'h0000, ext_g[15:13], d[12:0]});
      rd(H_DATA_ADDR, {21'h00_0000, d[26:16]});
      wr(G_FSEL_ADDR, 32'h02aa_aaaa);
      d = $urandom();
      ext_g <= d[15:0];
      settle();
      `CHK(fwd.external_irq_input, {3'b000, d[12:0]})
      `CHK(g_pad_oe, 16'h0000)
      wr(G_FSEL_ADDR, 32'h03ff_ffff);
      for (int i = 0; i < 6; i++) begin
         @(posedge mclk);
         d = $urandom();
         r = gph_drv_t'(14'($urandom()));
         drv <= r;
         ext_g <= d[15:0];
         settle();
         oe_x = {6'h00, 1'b1, 1'b0, r.spi1_serial_clock_oe, r.spi1_master_out_oe,
                 r.spi1_master_in_oe, 1'b1, 4'h0};
         lv = {6'h00, r.uart1_request_to_send, 1'b0, r.spi1_serial_clock_o,
               r.spi1_master_out_o, r.spi1_master_in_o, r.display_power_down, 4'h0};
         `CHK(g_pad_oe, oe_x)
         `CHK(g_pad_out & oe_x, lv & oe_x)
         lv = (oe_x & lv) | (~oe_x & d[15:0]);
         `CHK({fwd.timer_clock_input_1, fwd.uart1_clear_to_send}, lv[11:10])
         `CHK({fwd.spi1_serial_clock, fwd.spi1_master_out, fwd.spi1_master_in}, lv[7:5])
         `CHK({fwd.slave_select_1, fwd.slave_select_0, fwd.external_irq_input}, {lv[3:2], 16'h0})
      end
      wr(G_FSEL_ADDR, 32'h0000_0000);
      wr(H_FSEL_ADDR, 32'h002a_aaaa);
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         d = $urandom();
         r = gph_drv_t'(14'($urandom()));
         drv <= r;
         ext_h <= d[10:0];
         settle();
         lv = {5'h00, r.clock_output_1, r.clock_output_0, 2'b00, r.uart2_transmit, 1'b0,
               r.uart1_transmit, 1'b0, r.uart0_transmit, r.uart0_request_to_send, 1'b0};
         `CHK(h_pad_oe, 11'h656)
         `CHK(h_pad_out & 11'h656, lv[10:0])
         `CHK({fwd.uart_external_clock, fwd.uart2_receive, fwd.uart1_receive}, {d[8], d[7], d[5]})
         `CHK({fwd.uart0_receive, fwd.uart0_clear_to_send}, {d[3], d[0]})
      end
      wr(H_FSEL_ADDR, 32'h003f_ffff);
      d = $urandom();
      ext_h <= d[10:0];
      settle();
      `CHK({h_pad_oe, h_pad_out[6]}, {11'h040, r.uart1_request_to_send})
      `CHK(fwd.uart1_clear_to_send, d[7])
      `CHK({fwd.uart_external_clock, fwd.uart0_receive}, 2'b01)
      // A second reset in mid-run must bring every pin back to input.
      @(posedge mclk);
      rst_n <= 1'b0;
      @(posedge mclk);
      rst_n <= 1'b1;
      settle();
      `CHK({g_pad_oe, h_pad_oe, g_pullup_dis}, 43'h000_0000_fc00)
      rd(H_FSEL_ADDR, 32'h0000_0000);
      repeat (3) @(posedge mclk);
      conclude();
   end
endmodule
`default_nettype wire
